/* rtl/scs_pkg.sv */
// Shared constants and types of the system clock switch
`default_nettype none

package scs_pkg;

	// ****************************************************************
	// Register map and field layout
	// ****************************************************************
	localparam logic [31:0] OFS_OSC_CTRL = 32'h0000_0000;
	localparam logic [31:0] OFS_OSC_STAT = 32'h0000_0004;
	localparam logic [31:0] OFS_T1_CTRL = 32'h0000_0018;
	localparam int SEL_LSB = 0;
	localparam int FREQ_LSB = 3;
	localparam int T1_SEC_EN_BIT = 3;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_READY_BIT = 7;
	localparam logic [7:0] OSC_CTRL_RST = 8'h38;
	localparam logic [7:0] OSC_CTRL_WMASK = 8'h7B;
	localparam logic [7:0] T1_CTRL_RST = 8'h00;
	localparam logic [7:0] T1_CTRL_WMASK = 8'hFD;

	// ****************************************************************
	// Oscillator configuration and timing counts
	// ****************************************************************
	localparam logic [2:0] CFG_LP = 3'h0;
	localparam logic [2:0] CFG_XT = 3'h1;
	localparam logic [2:0] CFG_HS = 3'h2;
	localparam int CNT_W = 11;
	localparam logic [CNT_W-1:0] OST_CYCLES = 11'h400;
	localparam logic [CNT_W-1:0] SEC_READY_CYCLES = 11'h400;
	localparam logic [CNT_W-1:0] INT_STAB_CYCLES = 11'h040;

	// ****************************************************************
	// Bus encodings
	// ****************************************************************
	localparam logic HRESP_OKAY = 1'b0;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {SRC_DEFAULT, SRC_SECONDARY, SRC_INTERNAL}
		scs_src_t;
	typedef enum logic [1:0] {ST_RUN, ST_SETTLE, ST_PARK_OLD, ST_JOIN_NEW}
		scs_state_t;

endpackage : scs_pkg

`default_nettype wire

/* rtl/scs_mon_if.sv */
// Carrier between the switch core and one oscillator monitor
`default_nettype none

interface scs_mon_if;
	logic en;
	logic level;
	logic [scs_pkg::CNT_W-1:0] target;
	logic done;
	logic rise;

	modport mon (input en, input level, input target,
		output done, output rise);
	modport ctl (output en, output level, output target,
		input done, input rise);
endinterface : scs_mon_if

`default_nettype wire

/* rtl/scs_sync.sv */
// Two-stage synchroniser for pin levels
`default_nettype none

module scs_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_r <= '0;
			o_q <= '0;
		end else begin
			meta_r <= i_d;
			o_q <= meta_r;
		end
	end
endmodule : scs_sync

`default_nettype wire

/* rtl/scs_osc_monitor.sv */
// Counts rising edges of one oscillator until it is deemed stable
`default_nettype none

module scs_osc_monitor (
	input wire logic i_clk,
	input wire logic i_rst,
	scs_mon_if.mon mon
);
	logic level_d_r;
	logic [scs_pkg::CNT_W-1:0] cnt_r;
	logic done_r;
	logic rise_w;
	logic [scs_pkg::CNT_W-1:0] cnt_inc_w;

	assign rise_w = mon.level & ~level_d_r;
	assign cnt_inc_w = cnt_r + 1'b1;
	assign mon.rise = rise_w;
	assign mon.done = done_r;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			level_d_r <= 1'b0;
		end else begin
			level_d_r <= mon.level;
		end
	end

	// Disabling drops the count: a restarted oscillator must prove itself
	always_ff @(posedge i_clk) begin
		if (i_rst || !mon.en) begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end else if (rise_w && !done_r) begin
			cnt_r <= cnt_inc_w;
			done_r <= (cnt_inc_w == mon.target);
		end
	end
endmodule : scs_osc_monitor

`default_nettype wire

/* rtl/scs_top.sv */
// System clock source switch with register slave on AHB-Lite
//
// The AHB-Lite register port is this design's own decision.
`default_nettype none

module scs_top (
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	input wire logic I_OSC_DEFAULT,
	input wire logic I_OSC_SECONDARY,
	input wire logic I_OSC_INTERNAL,
	input wire logic [2:0] I_DEFAULT_OSC_CONFIG,
	input wire logic I_AUTO_INTERNAL_REQ,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	output logic O_SYSCLK,
	output logic O_SECONDARY_OSC_EN,
	output logic [3:0] O_INTERNAL_FREQ_SEL,
	output logic [1:0] O_ACTIVE_SRC
);

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic scs_pkg::scs_src_t src_of_sel(
		input logic [1:0] sel
	);
		if (sel[1]) begin
			return scs_pkg::SRC_INTERNAL;
		end else if (sel[0]) begin
			return scs_pkg::SRC_SECONDARY;
		end else begin
			return scs_pkg::SRC_DEFAULT;
		end
	endfunction : src_of_sel

	function automatic logic level_of(
		input scs_pkg::scs_src_t src,
		input logic [2:0] lv
	);
		unique case (src)
			scs_pkg::SRC_DEFAULT: return lv[0];
			scs_pkg::SRC_SECONDARY: return lv[1];
			scs_pkg::SRC_INTERNAL: return lv[2];
			default: return 1'b0;
		endcase
	endfunction : level_of

	function automatic logic [7:0] merge_write(
		input logic [7:0] old,
		input logic [7:0] wdata,
		input logic [7:0] wmask
	);
		return (old & ~wmask) | (wdata & wmask);
	endfunction : merge_write

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	logic [6:0] pins_q;
	logic [2:0] osc_lv_w;
	logic [2:0] cfg_w;
	logic auto_req_w;

	scs_sync #(.W(7)) u_pin_sync (
		.i_clk(I_REF_CLK),
		.i_rst(I_RST),
		.i_d({I_AUTO_INTERNAL_REQ, I_DEFAULT_OSC_CONFIG, I_OSC_INTERNAL,
			I_OSC_SECONDARY, I_OSC_DEFAULT}),
		.o_q(pins_q)
	);

	assign osc_lv_w = pins_q[2:0];
	assign cfg_w = pins_q[5:3];
	assign auto_req_w = pins_q[6];

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0] osc_ctrl_r;
	logic [7:0] osc_ctrl_nxt;
	logic [7:0] t1_ctrl_r;
	logic [7:0] t1_ctrl_nxt;
	logic [7:0] osc_stat_w;
	logic dp_valid_r;
	logic dp_write_r;
	logic [31:0] dp_addr_r;
	logic [31:0] hrdata_nxt;
	logic hreadyout_r;
	logic addr_phase_w;
	logic wr_ctrl_w;
	logic wr_t1_w;
	logic [1:0] sel_w;
	logic sec_en_w;

	scs_pkg::scs_src_t active_r;
	scs_pkg::scs_src_t pending_r;
	scs_pkg::scs_state_t state_r;
	logic sysclk_r;
	logic ext_done_r;

	// ****************************************************************
	// Oscillator monitors
	// ****************************************************************
	scs_mon_if ost_if ();
	scs_mon_if sec_if ();
	scs_mon_if int_if ();

	logic crystal_w;
	logic src_want_is_def_w;
	logic int_wanted_w;

	assign crystal_w = (cfg_w == scs_pkg::CFG_LP) ||
		(cfg_w == scs_pkg::CFG_XT) || (cfg_w == scs_pkg::CFG_HS);

	// Start-up timer watches only the default oscillator pin
	assign ost_if.level = osc_lv_w[0];
	assign ost_if.target = scs_pkg::OST_CYCLES;
	assign ost_if.en = src_want_is_def_w ||
		(active_r == scs_pkg::SRC_DEFAULT);

	assign sec_if.level = osc_lv_w[1];
	assign sec_if.target = scs_pkg::SEC_READY_CYCLES;
	assign sec_if.en = sec_en_w;

	assign int_if.level = osc_lv_w[2];
	assign int_if.target = scs_pkg::INT_STAB_CYCLES;
	assign int_if.en = int_wanted_w || (active_r == scs_pkg::SRC_INTERNAL);

	scs_osc_monitor u_ost (
		.i_clk(I_REF_CLK),
		.i_rst(I_RST),
		.mon(ost_if)
	);

	scs_osc_monitor u_sec_ready (
		.i_clk(I_REF_CLK),
		.i_rst(I_RST),
		.mon(sec_if)
	);

	scs_osc_monitor u_int_stab (
		.i_clk(I_REF_CLK),
		.i_rst(I_RST),
		.mon(int_if)
	);

	// ****************************************************************
	// Source request and stability
	// ****************************************************************
	scs_pkg::scs_src_t src_want_w;
	logic def_stable_w;
	logic pend_stable_w;
	logic old_low_w;
	logic new_low_w;

	assign sel_w = osc_ctrl_r[scs_pkg::SEL_LSB +: 2];
	assign sec_en_w = t1_ctrl_r[scs_pkg::T1_SEC_EN_BIT];

	// Fail-safe or two-speed override forces internal; select left alone
	assign src_want_w = auto_req_w ? scs_pkg::SRC_INTERNAL
		: src_of_sel(sel_w);
	assign src_want_is_def_w = (src_want_w == scs_pkg::SRC_DEFAULT);
	assign int_wanted_w = (src_want_w == scs_pkg::SRC_INTERNAL);

	// Non-crystal default modes need no start-up count
	assign def_stable_w = crystal_w ? ost_if.done : 1'b1;

	// The secondary source is only taken once its ready flag is up
	always_comb begin
		unique case (pending_r)
			scs_pkg::SRC_DEFAULT: pend_stable_w = def_stable_w;
			scs_pkg::SRC_SECONDARY: pend_stable_w = sec_if.done;
			scs_pkg::SRC_INTERNAL: pend_stable_w = int_if.done;
			default: pend_stable_w = 1'b0;
		endcase
	end

	assign old_low_w = ~level_of(active_r, osc_lv_w);
	assign new_low_w = ~level_of(pending_r, osc_lv_w);

	// ****************************************************************
	// Handover state machine
	// ****************************************************************
	scs_pkg::scs_state_t state_nxt;
	scs_pkg::scs_src_t active_nxt;
	scs_pkg::scs_src_t pending_nxt;
	logic sysclk_nxt;

	always_comb begin
		state_nxt = state_r;
		active_nxt = active_r;
		pending_nxt = pending_r;
		sysclk_nxt = level_of(active_r, osc_lv_w);
		unique case (state_r)
			scs_pkg::ST_RUN: begin
				if (src_want_w != active_r) begin
					pending_nxt = src_want_w;
					state_nxt = scs_pkg::ST_SETTLE;
				end
			end
			scs_pkg::ST_SETTLE: begin
				// Old source keeps running while the new one settles
				if (src_want_w == active_r) begin
					state_nxt = scs_pkg::ST_RUN;
				end else if (src_want_w != pending_r) begin
					pending_nxt = src_want_w;
				end else if (pend_stable_w) begin
					state_nxt = scs_pkg::ST_PARK_OLD;
				end
			end
			scs_pkg::ST_PARK_OLD: begin
				// Park only once the old clock is low: no runt high
				if (old_low_w) begin
					sysclk_nxt = 1'b0;
					state_nxt = scs_pkg::ST_JOIN_NEW;
				end
			end
			scs_pkg::ST_JOIN_NEW: begin
				sysclk_nxt = 1'b0;
				// Join while the new clock is low, so its next edge is clean
				if (new_low_w) begin
					active_nxt = pending_r;
					state_nxt = scs_pkg::ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			state_r <= scs_pkg::ST_RUN;
			active_r <= scs_pkg::SRC_DEFAULT;
			pending_r <= scs_pkg::SRC_DEFAULT;
			sysclk_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			active_r <= active_nxt;
			pending_r <= pending_nxt;
			sysclk_r <= sysclk_nxt;
		end
	end

	// Reports the external default source as running and, in crystal modes, counted
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			ext_done_r <= 1'b0;
		end else begin
			ext_done_r <= (active_r == scs_pkg::SRC_DEFAULT) &&
				(state_r == scs_pkg::ST_RUN) && def_stable_w;
		end
	end

	// ****************************************************************
	// AHB-Lite slave
	// ****************************************************************
	assign addr_phase_w = I_HSEL && I_HTRANS[1] && I_HREADY;
	assign wr_ctrl_w = dp_valid_r && dp_write_r &&
		(dp_addr_r == scs_pkg::OFS_OSC_CTRL);
	assign wr_t1_w = dp_valid_r && dp_write_r &&
		(dp_addr_r == scs_pkg::OFS_T1_CTRL);

	assign osc_ctrl_nxt = wr_ctrl_w ? merge_write(osc_ctrl_r,
		I_HWDATA[7:0], scs_pkg::OSC_CTRL_WMASK) : osc_ctrl_r;
	assign t1_ctrl_nxt = wr_t1_w ? merge_write(t1_ctrl_r,
		I_HWDATA[7:0], scs_pkg::T1_CTRL_WMASK) : t1_ctrl_r;

	always_comb begin
		osc_stat_w = 8'h00;
		osc_stat_w[scs_pkg::STAT_DONE_BIT] = ext_done_r;
		osc_stat_w[scs_pkg::STAT_BUSY_BIT] = (state_r != scs_pkg::ST_RUN);
		osc_stat_w[scs_pkg::STAT_READY_BIT] = sec_if.done;
	end

	// Read data uses next values so a read right after a write sees it
	always_comb begin
		hrdata_nxt = 32'h0000_0000;
		if (I_HADDR == scs_pkg::OFS_OSC_CTRL) begin
			hrdata_nxt[7:0] = osc_ctrl_nxt;
		end else if (I_HADDR == scs_pkg::OFS_OSC_STAT) begin
			hrdata_nxt[7:0] = osc_stat_w;
		end else if (I_HADDR == scs_pkg::OFS_T1_CTRL) begin
			hrdata_nxt[7:0] = t1_ctrl_nxt;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r <= 32'h0000_0000;
		end else begin
			dp_valid_r <= addr_phase_w;
			dp_write_r <= addr_phase_w && I_HWRITE;
			dp_addr_r <= I_HADDR;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			O_HRDATA <= 32'h0000_0000;
		end else if (addr_phase_w && !I_HWRITE) begin
			O_HRDATA <= hrdata_nxt;
		end
	end

	// Zero wait states: the slave never stretches a transfer
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			hreadyout_r <= 1'b1;
			O_HRESP <= scs_pkg::HRESP_OKAY;
		end else begin
			hreadyout_r <= 1'b1;
			O_HRESP <= scs_pkg::HRESP_OKAY;
		end
	end

	assign O_HREADYOUT = hreadyout_r;

	// Select field cleared by every reset; hardware never writes it
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			osc_ctrl_r <= scs_pkg::OSC_CTRL_RST;
			t1_ctrl_r <= scs_pkg::T1_CTRL_RST;
		end else begin
			osc_ctrl_r <= osc_ctrl_nxt;
			t1_ctrl_r <= t1_ctrl_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign O_SYSCLK = sysclk_r;
	assign O_SECONDARY_OSC_EN = t1_ctrl_r[scs_pkg::T1_SEC_EN_BIT];
	assign O_INTERNAL_FREQ_SEL = osc_ctrl_r[scs_pkg::FREQ_LSB +: 4];
	assign O_ACTIVE_SRC = active_r;

endmodule : scs_top

`default_nettype wire

/* verif/scs_osc_model.sv */
// Behavioural oscillator sources facing the clock switch
`default_nettype none
module scs_osc_model (
	input wire logic i_sec_en,
	output logic o_def,
	output logic o_sec,
	output logic o_int
);
	timeunit 1ns;
	timeprecision 100ps;
	// Periods of 60, 80 and 50 ns, each a multiple of the 10 ns reference
	initial begin
		o_def = 1'b0;
		forever #30 o_def = ~o_def;
	end
	// Secondary crystal stands low while its enable is clear
	initial begin
		o_sec = 1'b0;
		forever begin
			#40;
			o_sec = i_sec_en ? ~o_sec : 1'b0;
		end
	end
	initial begin
		o_int = 1'b0;
		// Offset keeps every toggle off a reference clock edge
		#2;
		forever #25 o_int = ~o_int;
	end
endmodule : scs_osc_model
`default_nettype wire

/* verif/scs_top_asserts.sv */
// Port-level checks of the system clock switch
`default_nettype none
module scs_top_asserts (
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	input wire logic I_OSC_DEFAULT,
	input wire logic I_OSC_SECONDARY,
	input wire logic I_OSC_INTERNAL,
	input wire logic O_SYSCLK,
	input wire logic O_SECONDARY_OSC_EN,
	input wire logic [3:0] O_INTERNAL_FREQ_SEL,
	input wire logic [1:0] O_ACTIVE_SRC
);
	logic wr_ctl_r;
	logic wr_t1_r;
	logic take;
	logic pin_sel;
	assign take = I_HSEL && I_HTRANS[1] && I_HREADY && I_HWRITE;
	assign pin_sel = O_ACTIVE_SRC == 2'h0 ? I_OSC_DEFAULT :
		(O_ACTIVE_SRC == 2'h1 ? I_OSC_SECONDARY : I_OSC_INTERNAL);
	always_ff @(posedge I_REF_CLK) begin
		wr_ctl_r <= take && I_HADDR == scs_pkg::OFS_OSC_CTRL;
		wr_t1_r <= take && I_HADDR == scs_pkg::OFS_T1_CTRL;
	end
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (I_RST);
	src_legal_a: assert property (
		O_ACTIVE_SRC != 2'h3) else $error("active source code 3");
	clean_handover_a: assert property (
		$changed(O_ACTIVE_SRC) |-> !$past(O_SYSCLK))
		else $error("handover while system clock high");
	clk_rise_src_a: assert property (
		($stable(O_ACTIVE_SRC)[*4] ##0 $rose(O_SYSCLK)) |->
		$past(pin_sel, 3)) else $error("clock rose without source");
	clk_fall_src_a: assert property (
		($stable(O_ACTIVE_SRC)[*4] ##0 $fell(O_SYSCLK)) |->
		!$past(pin_sel, 3)) else $error("clock fell without source");
	freq_write_a: assert property (
		$changed(O_INTERNAL_FREQ_SEL) |-> $past(wr_ctl_r) &&
		O_INTERNAL_FREQ_SEL == $past(I_HWDATA[6:3]))
		else $error("frequency select moved without write");
	sec_en_write_a: assert property (
		$changed(O_SECONDARY_OSC_EN) |-> $past(wr_t1_r) &&
		O_SECONDARY_OSC_EN == $past(I_HWDATA[3]))
		else $error("secondary enable moved without write");
	sec_needs_en_a: assert property (
		$changed(O_ACTIVE_SRC) && O_ACTIVE_SRC == 2'h1 |->
		O_SECONDARY_OSC_EN) else $error("secondary used while off");
	switch_settle_a: assert property (
		$changed(O_ACTIVE_SRC) |=> $stable(O_ACTIVE_SRC)[*8])
		else $error("source switched again at once");
	reset_state_a: assert property (disable iff (1'b0)
		I_RST |=> O_ACTIVE_SRC == 2'h0 && !O_SYSCLK &&
		O_INTERNAL_FREQ_SEL == 4'h7) else $error("bad reset state");
endmodule : scs_top_asserts
`default_nettype wire

/* verif/system_clock_switch_bench.sv */
// Self-checking bench of the system clock switch
`default_nettype none
module system_clock_switch_bench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [31:0] a; logic [31:0] w; logic [31:0] r;}
		scs_row_t;
	logic clk, rst, hsel, hwrite, auto, hready, sclk, sec_en, hresp;
	logic od, os, oi;
	logic [1:0] htrans, src;
	logic [2:0] cfg;
	logic [3:0] fsel;
	logic [31:0] haddr, hwdata, hrdata, d;
	int n_mismatch, num_checks, cyc, c0;
	scs_row_t rows[5];
	scs_top scs_top_i (.I_REF_CLK(clk), .I_RST(rst), .I_HSEL(hsel),
		.I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
		.I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
		.I_OSC_DEFAULT(od), .I_OSC_SECONDARY(os), .I_OSC_INTERNAL(oi),
		.I_DEFAULT_OSC_CONFIG(cfg), .I_AUTO_INTERNAL_REQ(auto),
		.O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
		.O_SYSCLK(sclk), .O_SECONDARY_OSC_EN(sec_en),
		.O_INTERNAL_FREQ_SEL(fsel), .O_ACTIVE_SRC(src));
	scs_osc_model scs_osc_model_i (.i_sec_en(sec_en), .o_def(od),
		.o_sec(os), .o_int(oi));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) cyc++;
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic [31:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] x;
		bus(a, 1'b1, wd, x);
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [31:0] x);
		bus(a, 1'b0, 32'h0000_0000, x);
	endtask : rd
	task automatic poll(input int b);
		logic [31:0] x;
		x = 32'h0000_0000;
		c0 = cyc;
		while (x[b] !== 1'b1) rd(scs_pkg::OFS_OSC_STAT, x);
	endtask : poll
	task automatic wait_src(input logic [1:0] s);
		int n;
		n = 0;
		@(negedge clk);
		while (src !== s && n < 20000) begin
			@(negedge clk);
			n++;
		end
		chk({30'h0, src}, {30'h0, s});
	endtask : wait_src
	initial begin
		#600us;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		rows = '{'{scs_pkg::OFS_T1_CTRL, 32'h0000_00FF, 32'h0000_00FD},
			'{scs_pkg::OFS_T1_CTRL, 32'h0000_0000, 32'h0000_0000},
			'{scs_pkg::OFS_OSC_CTRL, 32'h0000_00FC, 32'h0000_0078},
			'{scs_pkg::OFS_OSC_CTRL, 32'h0000_0000, 32'h0000_0000},
			'{32'h0000_0010, 32'h0000_00FF, 32'h0000_0000}};
		{rst, hsel, hwrite, auto, htrans, cfg} = {4'h8, 5'h01};
		{haddr, hwdata} = {32'h0000_0000, 32'h0000_0000};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(scs_pkg::OFS_OSC_CTRL, d);
		chk(d, {24'h00_0000, scs_pkg::OSC_CTRL_RST});
		chk({30'h0, src}, 32'h0000_0000);
		chk({31'h0, hresp}, 32'h0000_0000);
		poll(scs_pkg::STAT_DONE_BIT);
		chk(32'(cyc - c0 >= 5900), 32'h0000_0001);
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].w);
			rd(rows[k].a, d);
			chk(d, rows[k].r);
		end
		wr(scs_pkg::OFS_T1_CTRL, 32'h0000_0008);
		@(negedge clk);
		chk({31'h0, sec_en}, 32'h0000_0001);
		poll(scs_pkg::STAT_READY_BIT);
		chk(32'(cyc - c0 >= 7900), 32'h0000_0001);
		wr(scs_pkg::OFS_OSC_CTRL, 32'h0000_0001);
		wait_src(2'h1);
		rd(scs_pkg::OFS_OSC_STAT, d);
		chk({31'h0, d[0]}, 32'h0000_0000);
		wr(scs_pkg::OFS_OSC_CTRL, 32'h0000_003A);
		wait_src(2'h2);
		chk({28'h0, fsel}, 32'h0000_0007);
		wr(scs_pkg::OFS_OSC_CTRL, 32'h0000_004B);
		wait_src(2'h2);
		chk({28'h0, fsel}, 32'h0000_0009);
		wr(scs_pkg::OFS_T1_CTRL, 32'h0000_0000);
		rd(scs_pkg::OFS_OSC_STAT, d);
		chk({31'h0, d[7]}, 32'h0000_0000);
		wr(scs_pkg::OFS_OSC_CTRL, 32'h0000_0000);
		wait_src(2'h0);
		@(posedge clk);
		auto <= 1'b1;
		wait_src(2'h2);
		rd(scs_pkg::OFS_OSC_CTRL, d);
		chk({30'h0, d[1:0]}, 32'h0000_0000);
		rd(scs_pkg::OFS_OSC_STAT, d);
		chk({31'h0, d[0]}, 32'h0000_0000);
		@(posedge clk);
		auto <= 1'b0;
		wait_src(2'h0);
		wr(scs_pkg::OFS_OSC_CTRL, 32'h0000_0052);
		@(posedge clk);
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(scs_pkg::OFS_OSC_CTRL, d);
		chk(d, {24'h00_0000, scs_pkg::OSC_CTRL_RST});
		wait_src(2'h0);
		end_of_test();
	end
endmodule : system_clock_switch_bench
bind scs_top scs_top_asserts scs_top_asserts_i (.*);
`default_nettype wire
